// >>> sip_pkg.sv
/*
 * Constants for the sensor interrupt status, mask and pin block.
 * Assumes a 16-bit register word reached through the device's serial control port.
 */
package sip_pkg;
   // Register addresses on the serial control port
   localparam logic [7:0]  SIP_ADDR_STATUS   = 8'h00;  // Status and FIFO byte count
   localparam logic [7:0]  SIP_ADDR_MASK     = 8'h01;  // Interrupt mask
   localparam logic [7:0]  SIP_ADDR_PINCFG   = 8'h02;  // Pin output configuration
   // Status register fields
   localparam int          SIP_ST_CNT_LSB    = 8;      // Byte count field low bit
   localparam int          SIP_ST_FIFO_CLR   = 15;     // Write one clears the FIFO
   localparam int          SIP_ST_RSV7       = 7;      // Reserved flag bit seven
   localparam int          SIP_ST_SLOT_B     = 6;      // Second slot flag
   localparam int          SIP_ST_SLOT_A     = 5;      // First slot flag
   localparam int          SIP_ST_RSV_HI     = 4;      // Reserved low flags, top bit
   // Mask register fields
   localparam int          SIP_MK_FIFO       = 8;      // FIFO threshold irq disable
   localparam int          SIP_MK_SLOT_B     = 6;      // Second slot irq disable
   localparam int          SIP_MK_SLOT_A     = 5;      // First slot irq disable
   localparam int          SIP_MK_WIDTH      = 9;      // Stored mask bits [8:0]
   localparam logic [8:0]  SIP_MK_RESET      = 9'h1ff; // All sources disabled at reset
   // Pin configuration fields
   localparam int          SIP_PC_B_DRV      = 9;      // Pin B open-drain style
   localparam int          SIP_PC_B_POL      = 8;      // Pin B active low
   localparam int          SIP_PC_A_ENA      = 2;      // Pin A enable
   localparam int          SIP_PC_A_DRV      = 1;      // Pin A open-drain style
   localparam int          SIP_PC_A_POL      = 0;      // Pin A active low
   localparam logic [15:0] SIP_PC_RESET      = 16'h0000; // Pin config reset value
endpackage

// >>> sip_irq_top.sv
/*
 * Interrupt status, mask and interrupt pin logic of the smoke-sensing front end.
 * Assumes the serial port decoder and FIFO run on clk_in and give one-cycle strobes.
 */
`timescale 1ns/100ps
module sip_irq_top
   import sip_pkg::*;
#(
   parameter int CNT_W = 8,                             // FIFO byte count width
   parameter int THR_W = 6                              // FIFO word threshold width
) (
   input  wire logic             clk_in,                // 200 MHz device clock
   input  wire logic             rst_n_in,              // Async reset, active low
   input  wire logic             reg_wr_in,             // Register write strobe
   input  wire logic             reg_rd_in,             // Register read strobe
   input  wire logic [7:0]       reg_addr_in,           // Register address
   input  wire logic [15:0]      reg_wdata_in,          // Register write data
   output logic      [15:0]      reg_rdata_out,         // Register read data
   input  wire logic [CNT_W-1:0] fifo_byte_count_in,    // Bytes held in the FIFO
   input  wire logic [THR_W-1:0] fifo_word_threshold_in, // FIFO threshold in words
   output logic                  fifo_clear_out,        // Pulse: discard FIFO data
   input  wire logic             slot_a_sample_in,      // Pulse: first slot sample
   input  wire logic             slot_b_sample_in,      // Pulse: second slot sample
   input  wire logic [5:0]       rsv_event_in,          // Pulses for bit 7 and [4:0]
   output logic                  irq_out,               // Combined interrupt level
   output logic                  pin_a_out,             // Pin A level
   output logic                  pin_a_oe_out,          // Pin A output enable
   output logic                  pin_b_out,             // Pin B level
   output logic                  pin_b_oe_out           // Pin B output enable
);
   import sip_pkg::*;

   logic [1:0]              rst_sync_r;                 // Reset release synchroniser
   logic                    rst_n;                      // Synchronised reset
   logic                    slot_a_flag_r;              // first_slot_flag
   logic                    slot_b_flag_r;              // second_slot_flag
   logic [5:0]              rsv_flag_r;                 // {bit7, bits[4:0]}
   logic [SIP_MK_WIDTH-1:0] mask_r;                     // Stored mask bits
   logic [15:0]             pincfg_r;                   // Pin configuration
   logic [15:0]             rdata_r;                    // Read data holding
   logic                    fifo_clr_r;                 // FIFO clear pulse
   logic                    irq_r;                      // Registered interrupt
   logic                    pa_r, pa_oe_r, pb_r, pb_oe_r; // Registered pin drive

   // Decode of per-register write strobes
   wire        wr_status  = reg_wr_in && (reg_addr_in == SIP_ADDR_STATUS);
   wire        wr_mask    = reg_wr_in && (reg_addr_in == SIP_ADDR_MASK);
   wire        wr_pincfg  = reg_wr_in && (reg_addr_in == SIP_ADDR_PINCFG);
   // Write-one-to-clear vectors
   wire        clr_slot_a = wr_status && reg_wdata_in[SIP_ST_SLOT_A];
   wire        clr_slot_b = wr_status && reg_wdata_in[SIP_ST_SLOT_B];
   wire [5:0]  clr_rsv    = {6{wr_status}} &
                            {reg_wdata_in[SIP_ST_RSV7], reg_wdata_in[SIP_ST_RSV_HI:0]};
   // Threshold scaled from words to bytes, one bit wider so nothing is lost
   wire [THR_W:0] thr_bytes = {fifo_word_threshold_in, 1'b0};
   wire        fifo_over  = {1'b0, fifo_byte_count_in} > (CNT_W + 1)'(thr_bytes);
   // Unmasked sources ORed together
   wire        irq_nxt    = (fifo_over     && !mask_r[SIP_MK_FIFO])   ||
                            (slot_b_flag_r && !mask_r[SIP_MK_SLOT_B]) ||
                            (slot_a_flag_r && !mask_r[SIP_MK_SLOT_A]);
   // Pin levels follow polarity; open-drain drives only while asserted
   wire        pb_nxt     = irq_nxt ^ pincfg_r[SIP_PC_B_POL];
   wire        pb_oe_nxt  = !pincfg_r[SIP_PC_B_DRV] || irq_nxt;
   wire        pa_nxt     = irq_nxt ^ pincfg_r[SIP_PC_A_POL];
   wire        pa_oe_nxt  = pincfg_r[SIP_PC_A_ENA] &&
                            (!pincfg_r[SIP_PC_A_DRV] || irq_nxt);
   // Read multiplexer; unmapped addresses read zero
   wire [15:0] status_val = {fifo_byte_count_in[7:0], rsv_flag_r[5], slot_b_flag_r,
                             slot_a_flag_r, rsv_flag_r[4:0]};
   wire [15:0] rdata_nxt  = (reg_addr_in == SIP_ADDR_STATUS) ? status_val :
                            (reg_addr_in == SIP_ADDR_MASK)   ? {7'h00, mask_r} :
                            (reg_addr_in == SIP_ADDR_PINCFG) ? pincfg_r : 16'h0000;

   // Reset is asserted at once but released only after two clean edges
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) rst_sync_r <= 2'b00;
      else           rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   // Event flags; a set in the same cycle as its clear wins
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         slot_a_flag_r <= 1'b0;
         slot_b_flag_r <= 1'b0;
         rsv_flag_r    <= 6'h00;
      end else begin
         slot_a_flag_r <= slot_a_sample_in || (slot_a_flag_r && !clr_slot_a);
         slot_b_flag_r <= slot_b_sample_in || (slot_b_flag_r && !clr_slot_b);
         rsv_flag_r    <= rsv_event_in | (rsv_flag_r & ~clr_rsv);
      end
   end

   // Configuration registers and the FIFO clear strobe
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         mask_r     <= SIP_MK_RESET;
         pincfg_r   <= SIP_PC_RESET;
         fifo_clr_r <= 1'b0;
      end else begin
         if (wr_mask)   mask_r   <= reg_wdata_in[SIP_MK_WIDTH-1:0];
         if (wr_pincfg) pincfg_r <= reg_wdata_in;
         fifo_clr_r <= wr_status && reg_wdata_in[SIP_ST_FIFO_CLR];
      end
   end

   // Read data and pin drive registered so every output comes from a flop
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 16'h0000;
         irq_r   <= 1'b0;
         pa_r    <= 1'b0;
         pa_oe_r <= 1'b0;
         pb_r    <= 1'b0;
         pb_oe_r <= 1'b1;
      end else begin
         if (reg_rd_in) rdata_r <= rdata_nxt;
         irq_r   <= irq_nxt;
         pa_r    <= pa_nxt;
         pa_oe_r <= pa_oe_nxt;
         pb_r    <= pb_nxt;
         pb_oe_r <= pb_oe_nxt;
      end
   end

   assign reg_rdata_out  = rdata_r;
   assign fifo_clear_out = fifo_clr_r;
   assign irq_out        = irq_r;
   assign pin_a_out      = pa_r;
   assign pin_a_oe_out   = pa_oe_r;
   assign pin_b_out      = pb_r;
   assign pin_b_oe_out   = pb_oe_r;

   // Checks next to the logic they guard
   AST_FIFO_CLR: assert property (@(posedge clk_in) disable iff (!rst_n)
      wr_status && reg_wdata_in[SIP_ST_FIFO_CLR] |=> fifo_clear_out)
      else $error("FIFO clear pulse missing");
   AST_SLOT_B_SET: assert property (@(posedge clk_in) disable iff (!rst_n)
      slot_b_sample_in |=> slot_b_flag_r)
      else $error("Second slot flag not set");
   AST_SLOT_A_CLR: assert property (@(posedge clk_in) disable iff (!rst_n)
      clr_slot_a && !slot_a_sample_in |=> !slot_a_flag_r)
      else $error("First slot flag not cleared");
   AST_SLOT_A_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n)
      slot_a_flag_r && !clr_slot_a |=> slot_a_flag_r)
      else $error("First slot flag lost");
   AST_RSV_CLR: assert property (@(posedge clk_in) disable iff (!rst_n)
      wr_status && reg_wdata_in[4:0] == 5'h1f && rsv_event_in == 6'h00 |=>
      rsv_flag_r[4:0] == 5'h00)
      else $error("Reserved flags not cleared");
   AST_FIFO_IRQ: assert property (@(posedge clk_in) disable iff (!rst_n)
      fifo_byte_count_in > 2 * fifo_word_threshold_in && !mask_r[SIP_MK_FIFO] |=> irq_out)
      else $error("FIFO threshold irq missing");
   AST_MASKED_OFF: assert property (@(posedge clk_in) disable iff (!rst_n)
      mask_r[8] && mask_r[6] && mask_r[5] |=> !irq_out)
      else $error("Irq raised while all sources masked");
   AST_PIN_B_POL: assert property (@(posedge clk_in) disable iff (!rst_n)
      ##1 pin_b_out == (irq_out ^ $past(pincfg_r[SIP_PC_B_POL])))
      else $error("Pin B polarity wrong");
   AST_PIN_B_OD: assert property (@(posedge clk_in) disable iff (!rst_n)
      pincfg_r[SIP_PC_B_DRV] && !irq_nxt |=> !pin_b_oe_out)
      else $error("Pin B driven while idle in open drain");
   AST_PIN_A_OFF: assert property (@(posedge clk_in) disable iff (!rst_n)
      !pincfg_r[SIP_PC_A_ENA] |=> !pin_a_oe_out)
      else $error("Pin A driven while disabled");
   // A clear only wins when no event arrives in the same cycle
   AST_SLOT_B_CLR: assert property (@(posedge clk_in) disable iff (!rst_n)
      clr_slot_b && !slot_b_sample_in |=> !slot_b_flag_r)
      else $error("Second slot flag not cleared");
   AST_RSV7_CLR: assert property (@(posedge clk_in) disable iff (!rst_n)
      wr_status && reg_wdata_in[SIP_ST_RSV7] && !rsv_event_in[5] |=> !rsv_flag_r[5])
      else $error("Status bit seven not cleared");
   // Each unmasked source alone must raise the combined interrupt
   AST_SLOT_B_IRQ: assert property (@(posedge clk_in) disable iff (!rst_n)
      slot_b_flag_r && !mask_r[SIP_MK_SLOT_B] |=> irq_out)
      else $error("Second slot irq missing");
   AST_SLOT_A_IRQ: assert property (@(posedge clk_in) disable iff (!rst_n)
      slot_a_flag_r && !mask_r[SIP_MK_SLOT_A] |=> irq_out)
      else $error("First slot irq missing");
   // FIFO irq must fall on its own once the level is back at or below the threshold
   AST_FIFO_DROP: assert property (@(posedge clk_in) disable iff (!rst_n)
      fifo_byte_count_in <= 2 * fifo_word_threshold_in &&
      !(slot_a_flag_r && !mask_r[SIP_MK_SLOT_A]) &&
      !(slot_b_flag_r && !mask_r[SIP_MK_SLOT_B]) |=> !irq_out)
      else $error("FIFO irq did not drop");
   AST_COUNT_RD: assert property (@(posedge clk_in) disable iff (!rst_n)
      reg_rd_in && reg_addr_in == SIP_ADDR_STATUS |=>
      reg_rdata_out[15:SIP_ST_CNT_LSB] == $past(fifo_byte_count_in[7:0]))
      else $error("Status read lost the byte count");
   // Disabling pin A must not freeze the status flags behind it
   AST_PIN_A_STATUS: assert property (@(posedge clk_in) disable iff (!rst_n)
      slot_a_sample_in && !pincfg_r[SIP_PC_A_ENA] |=> slot_a_flag_r)
      else $error("Status frozen while pin A disabled");
   AST_PIN_B_PP: assert property (@(posedge clk_in) disable iff (!rst_n)
      !pincfg_r[SIP_PC_B_DRV] |=> pin_b_oe_out)
      else $error("Pin B floated in push-pull mode");
   // Scenario covers
   COV_PIN_A_OD: cover property (@(posedge clk_in) disable iff (!rst_n)
      pincfg_r[SIP_PC_A_ENA] && pincfg_r[SIP_PC_A_DRV] && !irq_nxt);
   COV_SLOT_IRQ: cover property (@(posedge clk_in) disable iff (!rst_n)
      slot_a_sample_in && !mask_r[SIP_MK_SLOT_A] ##1 irq_out);
   COV_FIFO_IRQ: cover property (@(posedge clk_in) disable iff (!rst_n)
      irq_out && fifo_over ##1 !fifo_over ##1 !irq_out);
   COV_SET_CLR: cover property (@(posedge clk_in) disable iff (!rst_n)
      slot_b_sample_in && clr_slot_b);
endmodule

// >>> sip_host_model.sv
/* Host model: drives the register strobes of the interrupt block.
   Assumes the bench calls its tasks only after the internal reset has ended. */
`timescale 1ns/100ps
module sip_host_model (
   input  wire logic        clk_in,     // Device clock
   input  wire logic [15:0] rdata_in,   // Registered read data
   output logic             wr_out,     // Write strobe
   output logic             rd_out,     // Read strobe
   output logic [7:0]       addr_out,   // Register address
   output logic [15:0]      wdata_out   // Write data
);
   // Idle bus at time zero so no strobe is seen as unknown
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 16'h0000;
   end
   // One write; strobe lives for exactly one taken edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
   endtask
   // One read; data is taken just after the edge that captured it
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      #1 d = rdata_in;
   endtask
endmodule

// >>> tb.sv
/* Self-checking bench for the interrupt status, mask and pin block.
   Assumes the host model for register traffic; events and FIFO level come from here. */
`timescale 1ns/100ps
module tb;
   logic        clk, rst_n, sa, sb, wr, rd, clr, irq, pa, pao, pb, pbo;
   logic [7:0]  cnt, addr;     // FIFO byte count, register address
   logic [5:0]  thr, rsv;      // Word threshold, reserved event pulses
   logic [15:0] wd, rdat, d, nclr; // Write data, read data, sampled word, clear pulses
   int          errors, checks;
   sip_host_model host (.clk_in(clk), .rdata_in(rdat), .wr_out(wr), .rd_out(rd),
      .addr_out(addr), .wdata_out(wd));
   sip_irq_top uut (.clk_in(clk), .rst_n_in(rst_n), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rdat),
      .fifo_byte_count_in(cnt), .fifo_word_threshold_in(thr), .fifo_clear_out(clr),
      .slot_a_sample_in(sa), .slot_b_sample_in(sb), .rsv_event_in(rsv), .irq_out(irq),
      .pin_a_out(pa), .pin_a_oe_out(pao), .pin_b_out(pb), .pin_b_oe_out(pbo));
   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", n, e, g);
         errors++;
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [15:0] e, input string n);
      host.rd(a, d);
      chk(n, e, d);
   endtask
   // Let register and pin flops settle before looking
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   // Pins compared as {irq, pin A enable, pin A level, pin B level, pin B enable}
   task automatic pins(input logic [4:0] e);
      chk("irq_pins", {11'h000, e}, {11'h000, irq, pao, pa, pb, pbo});
   endtask
   task automatic ev(input logic a, input logic b, input logic [5:0] r);
      @(posedge clk);
      sa <= a;
      sb <= b;
      rsv <= r;
      @(posedge clk);
      sa <= 1'b0;
      sb <= 1'b0;
      rsv <= 6'h00;
      settle();
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard far beyond the test length
   initial begin
      #200000;
      errors++;
      complete_run();
   end
   initial begin
      {rst_n, sa, sb, cnt, thr, rsv, errors, checks, nclr} = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rchk(8'h01, 16'h01ff, "mask_reset");
      rchk(8'h02, 16'h0000, "pincfg_reset");
      rchk(8'h03, 16'h0000, "unmapped");
      pins(5'b00001);
      @(posedge clk);
      cnt <= 8'h2a;
      settle();
      rchk(8'h00, 16'h2a00, "byte_count");
      host.wr(8'h00, 16'h8000);
      for (int i = 0; i < 4; i++) begin
         #1 nclr += {15'h0000, clr};
         @(posedge clk);
      end
      chk("fifo_clear", 16'h0001, nclr);
      $display("test registers done");
      ev(1'b1, 1'b1, 6'h3f);
      rchk(8'h00, 16'h2aff, "flags_set");
      pins(5'b00001);
      host.wr(8'h00, 16'h0020);
      rchk(8'h00, 16'h2adf, "clear_a");
      host.wr(8'h00, 16'h0000);
      rchk(8'h00, 16'h2adf, "write_zero");
      host.wr(8'h00, 16'h0080);
      rchk(8'h00, 16'h2a5f, "clear_bit7");
      host.wr(8'h00, 16'h001f);
      rchk(8'h00, 16'h2a40, "clear_low");
      host.wr(8'h00, 16'h0040);
      rchk(8'h00, 16'h2a00, "clear_b");
      $display("test flags done");
      host.wr(8'h01, 16'h01df);
      ev(1'b1, 1'b0, 6'h00);
      pins(5'b10111);
      host.wr(8'h02, 16'h0307);
      rchk(8'h02, 16'h0307, "pincfg_rw");
      settle();
      pins(5'b11001);
      host.wr(8'h00, 16'h0020);
      ev(1'b0, 1'b1, 6'h00);
      pins(5'b00110);
      host.wr(8'h02, 16'h0000);
      host.wr(8'h00, 16'h0040);
      $display("test pins done");
      thr <= 6'd5;
      cnt <= 8'd11;
      host.wr(8'h01, 16'h00ff);
      settle();
      pins(5'b10111);
      @(posedge clk);
      cnt <= 8'd10;
      settle();
      pins(5'b00001);
      @(posedge clk);
      cnt <= 8'd11;
      host.wr(8'h01, 16'h01ff);
      settle();
      pins(5'b00001);
      $display("test fifo level done");
      complete_run();
   end
endmodule
